// ==== design/dci_defines.svh ====
`ifndef DCI_DEFINES_SVH
`define DCI_DEFINES_SVH
// register offsets on the serial control port
`define DCI_OFS_STYLE 7'h39
`define DCI_OFS_TX_TUNE 7'h3A
`define DCI_OFS_RX_TUNE 7'h3B
`define DCI_OFS_TAP 7'h3C
`define DCI_OFS_NEGATE 7'h3D
`define DCI_OFS_PULSE 7'h3E
`define DCI_OFS_RX_IF 7'h3F
// doubler style register fields
`define DCI_BIT_RX_DBL_RST 7
`define DCI_BIT_TX_DBL_RST 6
`define DCI_BIT_RX_STYLE 1
`define DCI_BIT_TX_STYLE 0
`define DCI_MASK_STYLE 8'h03
// sign inversion fields
`define DCI_BIT_RX_Q_NEG 3
`define DCI_BIT_RX_I_NEG 2
`define DCI_BIT_TX_Q_NEG 1
`define DCI_BIT_TX_I_NEG 0
`define DCI_MASK_NEGATE 8'h0F
// pulse width fields
`define DCI_TX_PW_HI 5
`define DCI_TX_PW_LO 3
`define DCI_RX_PW_HI 2
`define DCI_RX_PW_LO 0
`define DCI_MASK_PULSE 8'h3F
// receive interface fields
`define DCI_BIT_RX_CLK_SEL 6
`define DCI_BIT_RX_BUS_SEL 5
`define DCI_BIT_SINGLE_RX 4
`define DCI_BIT_TRANSMIT_CLOCK_PIN_BEH 3
`define DCI_BIT_HD_BUS_PIN 2
`define DCI_BIT_HD_SUBMODE 1
`define DCI_BIT_FULL_DUPLEX 0
`define DCI_MASK_RX_IF 8'h7F
// reset values
`define DCI_RST_STYLE 8'h00
`define DCI_RST_TUNE 8'h55
`define DCI_RST_TAP 8'h00
`define DCI_RST_NEGATE 8'h00
`define DCI_RST_PULSE 8'h00
`define DCI_RST_RX_IF 8'h00
// sample format
`define DCI_SAMPLE_W 12
`define DCI_SAMPLE_MAX 12'h07FF
`define DCI_SAMPLE_MIN 12'h0800
`endif

// ==== design/dci_pkg.sv ====
package dci_pkg;
  // one register write from the serial port
  typedef struct packed {
    logic wr;
    logic [6:0] addr;
    logic [7:0] data;
  } dci_wreq_t;
  // one i/q sample pair
  typedef struct packed {
    logic [11:0] i;
    logic [11:0] q;
  } dci_pair_t;
  // serial frame phase
  typedef enum logic [1:0] {DCI_SP_CMD, DCI_SP_LOAD, DCI_SP_DATA} dci_sp_state_t;
endpackage

// ==== design/dci_serial_port.sv ====
`timescale 1ns/10ps
// 16-bit frame, msb first: read flag, 7-bit address, 8 data bits
module dci_serial_port (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // serial pins
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic sdi_in,
  output logic sdo_out,
  output logic sdo_oe_out,
  // register side
  input wire logic [7:0] rdata_in,
  output logic [6:0] raddr_out,
  output dci_pkg::dci_wreq_t wreq_out
);
  logic sclk_r;
  logic rd_r;
  logic [4:0] cnt_r;
  logic [14:0] shift_r;
  logic [7:0] out_r;
  dci_pkg::dci_sp_state_t state_r;
  logic rise;
  logic fall;

  // sclk is sampled by clk_in, so it must run well below 50 MHz
  assign rise = sclk_in & ~sclk_r & ~cs_n_in;
  assign fall = ~sclk_in & sclk_r & ~cs_n_in;

  // edge history
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      sclk_r <= 1'b0;
    else
      sclk_r <= sclk_in;
  end

  // frame sequencing
  always_ff @(posedge clk_in)
  begin
    if (reset_in || cs_n_in)
    begin
      state_r <= dci_pkg::DCI_SP_CMD;
      cnt_r <= 5'h00;
      shift_r <= 15'h0000;
      rd_r <= 1'b0;
      raddr_out <= 7'h00;
      wreq_out <= '0;
    end
    else
    begin
      wreq_out.wr <= 1'b0;
      if (rise)
      begin
        shift_r <= {shift_r[13:0], sdi_in};
        cnt_r <= cnt_r + 5'h01;
      end
      unique case (state_r)
        dci_pkg::DCI_SP_CMD:
          if (rise && cnt_r == 5'h07)
          begin
            rd_r <= shift_r[6];
            raddr_out <= {shift_r[5:0], sdi_in};
            state_r <= dci_pkg::DCI_SP_LOAD;
          end
        dci_pkg::DCI_SP_LOAD:
          state_r <= dci_pkg::DCI_SP_DATA;
        dci_pkg::DCI_SP_DATA:
          if (rise && cnt_r == 5'h0F)
          begin
            wreq_out.wr <= ~rd_r;
            wreq_out.addr <= raddr_out;
            wreq_out.data <= {shift_r[6:0], sdi_in};
            cnt_r <= 5'h00;
            state_r <= dci_pkg::DCI_SP_CMD;
          end
        // the unused fourth code falls back to the command phase
        default:
          state_r <= dci_pkg::DCI_SP_CMD;
      endcase
    end
  end

  // read data leaves on falling sclk so the master samples it on rising
  always_ff @(posedge clk_in)
  begin
    if (reset_in || cs_n_in)
    begin
      out_r <= 8'h00;
      sdo_out <= 1'b0;
      sdo_oe_out <= 1'b0;
    end
    else if (state_r == dci_pkg::DCI_SP_LOAD)
      out_r <= rdata_in;
    else if (state_r == dci_pkg::DCI_SP_DATA && rd_r && fall)
    begin
      sdo_out <= out_r[7];
      sdo_oe_out <= 1'b1;
      out_r <= {out_r[6:0], 1'b0};
    end
  end
endmodule

// ==== design/dci_config_top.sv ====
`timescale 1ns/10ps
`include "dci_defines.svh"
module dci_config_top (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // serial control port
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic sdi_in,
  output logic sdo_out,
  output logic sdo_oe_out,
  // converter samples
  input wire dci_pkg::dci_pair_t rx_adc_in,
  input wire dci_pkg::dci_pair_t tx_host_in,
  input wire logic dll_clk_in,
  output dci_pkg::dci_pair_t rx_host_out,
  output logic [11:0] rx_single_out,
  output dci_pkg::dci_pair_t tx_dac_out,
  // receive path steering
  output logic [1:0] rx_path_enable_out,
  output logic rx_clock_i_side_out,
  // interface mode
  output logic full_duplex_out,
  output logic half_duplex_clock_submode_out,
  output logic half_duplex_bus_pin_ctl_out,
  output logic transmit_clock_pin_out,
  output logic transmit_clock_pin_oe_out,
  // clock doubler controls
  output logic rx_doubler_style_out,
  output logic tx_doubler_style_out,
  output logic receive_doubler_reset_out,
  output logic transmit_doubler_reset_out,
  output logic [7:0] tx_doubler_tuning_out,
  output logic [7:0] rx_doubler_tuning_out,
  output logic [7:0] doubler_initial_tap_delay_out,
  output logic [2:0] tx_doubler_pulse_width_out,
  output logic [2:0] rx_doubler_pulse_width_out
);
  logic [7:0] style_r;
  logic [7:0] tx_tune_r;
  logic [7:0] rx_tune_r;
  logic [7:0] tap_r;
  logic [7:0] negate_r;
  logic [7:0] pulse_r;
  logic [7:0] rx_if_r;
  logic [7:0] rdata;
  logic [6:0] raddr;
  logic one_clock_mode;
  dci_pkg::dci_wreq_t wreq;

  // two's complement negate; the most negative code saturates
  // because its true negation does not fit in 12 bits
  function automatic logic [11:0] dci_negate(input logic [11:0] s, input logic en);
    logic [11:0] r;
    r = s;
    if (en)
      r = (s == `DCI_SAMPLE_MIN) ? `DCI_SAMPLE_MAX : 12'(~s + 12'h001);
    return r;
  endfunction

  dci_serial_port u_port (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .sclk_in(sclk_in),
    .cs_n_in(cs_n_in),
    .sdi_in(sdi_in),
    .sdo_out(sdo_out),
    .sdo_oe_out(sdo_oe_out),
    .rdata_in(rdata),
    .raddr_out(raddr),
    .wreq_out(wreq)
  );

  // register writes; unused bits are masked at the write
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      style_r <= `DCI_RST_STYLE;
      tx_tune_r <= `DCI_RST_TUNE;
      rx_tune_r <= `DCI_RST_TUNE;
      tap_r <= `DCI_RST_TAP;
      negate_r <= `DCI_RST_NEGATE;
      pulse_r <= `DCI_RST_PULSE;
      rx_if_r <= `DCI_RST_RX_IF;
    end
    else if (wreq.wr)
    begin
      unique case (wreq.addr)
        `DCI_OFS_STYLE: style_r <= wreq.data & `DCI_MASK_STYLE;
        `DCI_OFS_TX_TUNE: tx_tune_r <= wreq.data;
        `DCI_OFS_RX_TUNE: rx_tune_r <= wreq.data;
        `DCI_OFS_TAP: tap_r <= wreq.data;
        `DCI_OFS_NEGATE: negate_r <= wreq.data & `DCI_MASK_NEGATE;
        `DCI_OFS_PULSE: pulse_r <= wreq.data & `DCI_MASK_PULSE;
        `DCI_OFS_RX_IF: rx_if_r <= wreq.data & `DCI_MASK_RX_IF;
        default: ;
      endcase
    end
  end

  // read mux; unmapped addresses read zero
  always_comb
  begin
    unique case (raddr)
      `DCI_OFS_STYLE: rdata = style_r;
      `DCI_OFS_TX_TUNE: rdata = tx_tune_r;
      `DCI_OFS_RX_TUNE: rdata = rx_tune_r;
      `DCI_OFS_TAP: rdata = tap_r;
      `DCI_OFS_NEGATE: rdata = negate_r;
      `DCI_OFS_PULSE: rdata = pulse_r;
      `DCI_OFS_RX_IF: rdata = rx_if_r;
      default: rdata = 8'h00;
    endcase
  end

  // doubler reset bits self-clear: one pulse per write of 1
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      receive_doubler_reset_out <= 1'b0;
      transmit_doubler_reset_out <= 1'b0;
    end
    else
    begin
      receive_doubler_reset_out <= wreq.wr && wreq.addr == `DCI_OFS_STYLE
        && wreq.data[`DCI_BIT_RX_DBL_RST];
      transmit_doubler_reset_out <= wreq.wr && wreq.addr == `DCI_OFS_STYLE
        && wreq.data[`DCI_BIT_TX_DBL_RST];
    end
  end

  // doubler settings; outputs trail the registers by one cycle
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      rx_doubler_style_out <= 1'b0;
      tx_doubler_style_out <= 1'b0;
      tx_doubler_tuning_out <= `DCI_RST_TUNE;
      rx_doubler_tuning_out <= `DCI_RST_TUNE;
      doubler_initial_tap_delay_out <= `DCI_RST_TAP;
      tx_doubler_pulse_width_out <= 3'h0;
      rx_doubler_pulse_width_out <= 3'h0;
    end
    else
    begin
      rx_doubler_style_out <= style_r[`DCI_BIT_RX_STYLE];
      tx_doubler_style_out <= style_r[`DCI_BIT_TX_STYLE];
      tx_doubler_tuning_out <= tx_tune_r;
      rx_doubler_tuning_out <= rx_tune_r;
      doubler_initial_tap_delay_out <= tap_r;
      tx_doubler_pulse_width_out <= pulse_r[`DCI_TX_PW_HI:`DCI_TX_PW_LO];
      rx_doubler_pulse_width_out <= pulse_r[`DCI_RX_PW_HI:`DCI_RX_PW_LO];
    end
  end

  // half duplex with the one-clock submode
  assign one_clock_mode = ~rx_if_r[`DCI_BIT_FULL_DUPLEX] & ~rx_if_r[`DCI_BIT_HD_SUBMODE];

  // interface mode and transmit clock pin; dll clock is retimed, so
  // it must be slower than half of clk_in to pass intact
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      full_duplex_out <= 1'b0;
      half_duplex_clock_submode_out <= 1'b0;
      half_duplex_bus_pin_ctl_out <= 1'b0;
      transmit_clock_pin_out <= 1'b0;
      transmit_clock_pin_oe_out <= 1'b0;
    end
    else
    begin
      full_duplex_out <= rx_if_r[`DCI_BIT_FULL_DUPLEX];
      half_duplex_clock_submode_out <= rx_if_r[`DCI_BIT_HD_SUBMODE];
      half_duplex_bus_pin_ctl_out <= rx_if_r[`DCI_BIT_HD_BUS_PIN];
      transmit_clock_pin_out <= dll_clk_in & rx_if_r[`DCI_BIT_TRANSMIT_CLOCK_PIN_BEH];
      transmit_clock_pin_oe_out <= one_clock_mode & rx_if_r[`DCI_BIT_TRANSMIT_CLOCK_PIN_BEH];
    end
  end

  // receive steering
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      rx_path_enable_out <= 2'b11;
      rx_clock_i_side_out <= 1'b0;
    end
    else if (rx_if_r[`DCI_BIT_SINGLE_RX])
    begin
      rx_path_enable_out <= rx_if_r[`DCI_BIT_RX_BUS_SEL] ? 2'b10 : 2'b01;
      rx_clock_i_side_out <= rx_if_r[`DCI_BIT_RX_CLK_SEL];
    end
    else
    begin
      rx_path_enable_out <= 2'b11;
      rx_clock_i_side_out <= 1'b0;
    end
  end

  // sample paths, one register stage each
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      rx_host_out <= '0;
      rx_single_out <= 12'h000;
      tx_dac_out <= '0;
    end
    else
    begin
      rx_host_out.q <= dci_negate(rx_adc_in.q, negate_r[`DCI_BIT_RX_Q_NEG]);
      rx_host_out.i <= dci_negate(rx_adc_in.i, negate_r[`DCI_BIT_RX_I_NEG]);
      tx_dac_out.q <= dci_negate(tx_host_in.q, negate_r[`DCI_BIT_TX_Q_NEG]);
      tx_dac_out.i <= dci_negate(tx_host_in.i, negate_r[`DCI_BIT_TX_I_NEG]);
      rx_single_out <= rx_if_r[`DCI_BIT_RX_BUS_SEL]
        ? dci_negate(rx_adc_in.i, negate_r[`DCI_BIT_RX_I_NEG])
        : dci_negate(rx_adc_in.q, negate_r[`DCI_BIT_RX_Q_NEG]);
    end
  end

  // checks
  property p_rx_q_negate;
    @(posedge clk_in) disable iff (reset_in)
    negate_r[3] && rx_adc_in.q != 12'h800
      |=> 12'(rx_host_out.q + $past(rx_adc_in.q)) == 12'h000;
  endproperty
  a_rx_q_negate: assert property (p_rx_q_negate) else $error("rx q not negated");

  property p_rx_i_pass;
    @(posedge clk_in) disable iff (reset_in)
    !negate_r[2] |=> rx_host_out.i == $past(rx_adc_in.i);
  endproperty
  a_rx_i_pass: assert property (p_rx_i_pass) else $error("rx i altered");

  property p_tx_q_negate;
    @(posedge clk_in) disable iff (reset_in)
    negate_r[1] |=> ($past(tx_host_in.q) == 12'h800) ? tx_dac_out.q == 12'h7FF
      : 12'(tx_dac_out.q + $past(tx_host_in.q)) == 12'h000;
  endproperty
  a_tx_q_negate: assert property (p_tx_q_negate) else $error("tx q not negated");

  property p_tx_i_sum;
    @(posedge clk_in) disable iff (reset_in)
    negate_r[0] && tx_host_in.i != 12'h800 |=> 12'(tx_dac_out.i + $past(tx_host_in.i)) == 12'h000;
  endproperty
  a_tx_i_sum: assert property (p_tx_i_sum) else $error("tx i not negated");

  property p_pin_ignored;
    @(posedge clk_in) disable iff (reset_in)
    (rx_if_r[0] || rx_if_r[1]) |=> !transmit_clock_pin_oe_out;
  endproperty
  a_pin_ignored: assert property (p_pin_ignored) else $error("tx clock pin driven");

  property p_pin_driven;
    @(posedge clk_in) disable iff (reset_in)
    !rx_if_r[0] && !rx_if_r[1] && rx_if_r[3] ##1 rx_if_r[3] |-> transmit_clock_pin_oe_out;
  endproperty
  a_pin_driven: assert property (p_pin_driven) else $error("tx clock pin idle");

  property p_dbl_reset;
    @(posedge clk_in) disable iff (reset_in)
    wreq.wr && wreq.addr == 7'h39 && wreq.data[7] |=> receive_doubler_reset_out
      ##1 !receive_doubler_reset_out || $past(wreq.wr);
  endproperty
  a_dbl_reset: assert property (p_dbl_reset) else $error("rx doubler reset pulse");

  property p_single_path;
    @(posedge clk_in) disable iff (reset_in)
    rx_if_r[4] ##1 rx_if_r[4] |-> rx_path_enable_out != 2'b11;
  endproperty
  a_single_path: assert property (p_single_path) else $error("both paths on");

  property p_unused_zero;
    @(posedge clk_in) disable iff (reset_in)
    wreq.wr && wreq.addr == 7'h3D |=> negate_r[7:4] == 4'h0
      && negate_r[3:0] == $past(wreq.data[3:0]);
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("negate reg write");

  property p_pulse_width;
    @(posedge clk_in) disable iff (reset_in)
    wreq.wr && wreq.addr == 7'h3E |-> ##2 tx_doubler_pulse_width_out == $past(wreq.data[5:3], 2);
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("tx pulse width");

  c_write: cover property (@(posedge clk_in) wreq.wr && wreq.addr == 7'h3F);
  c_single_i: cover property (@(posedge clk_in) rx_path_enable_out == 2'b10);
  c_pin_on: cover property (@(posedge clk_in) transmit_clock_pin_oe_out);
endmodule

// ==== sim/dci_config_top_tb_top.sv ====
`timescale 1ns/10ps
module dci_config_top_tb_top;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic sclk = 1'b0;
  logic cs_n = 1'b1;
  logic sdi = 1'b0;
  logic dll = 1'b0;
  dci_pkg::dci_pair_t rx_adc = '0;
  dci_pkg::dci_pair_t tx_host = '0;
  logic sdo_out, sdo_oe_out;
  dci_pkg::dci_pair_t rx_host_out, tx_dac_out;
  logic [11:0] rx_single_out;
  logic [1:0] rx_path_enable_out;
  logic rx_clock_i_side_out, full_duplex_out, hd_submode, hd_bus_pin, transmit_clock_pin_pin, transmit_clock_pin_oe;
  logic rx_style, tx_style, rx_dbl_rst, tx_dbl_rst;
  logic [7:0] tx_tune, rx_tune, tap_dly;
  logic [2:0] tx_pw, rx_pw;
  int num_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  int rx_pulses = 0;
  int tx_pulses = 0;
  logic [7:0] m [57:63];

  // 100 MHz clock
  always #5 clk_in = ~clk_in;

  dci_config_top dci_config_top_i (
    .clk_in(clk_in), .reset_in(reset_in), .sclk_in(sclk), .cs_n_in(cs_n), .sdi_in(sdi),
    .sdo_out(sdo_out), .sdo_oe_out(sdo_oe_out), .rx_adc_in(rx_adc), .tx_host_in(tx_host),
    .dll_clk_in(dll), .rx_host_out(rx_host_out), .rx_single_out(rx_single_out),
    .tx_dac_out(tx_dac_out), .rx_path_enable_out(rx_path_enable_out),
    .rx_clock_i_side_out(rx_clock_i_side_out), .full_duplex_out(full_duplex_out),
    .half_duplex_clock_submode_out(hd_submode), .half_duplex_bus_pin_ctl_out(hd_bus_pin),
    .transmit_clock_pin_out(transmit_clock_pin_pin), .transmit_clock_pin_oe_out(transmit_clock_pin_oe),
    .rx_doubler_style_out(rx_style), .tx_doubler_style_out(tx_style),
    .receive_doubler_reset_out(rx_dbl_rst), .transmit_doubler_reset_out(tx_dbl_rst),
    .tx_doubler_tuning_out(tx_tune), .rx_doubler_tuning_out(rx_tune),
    .doubler_initial_tap_delay_out(tap_dly), .tx_doubler_pulse_width_out(tx_pw),
    .rx_doubler_pulse_width_out(rx_pw)
  );

  // doubler reset pulses counted mid-cycle, away from the launching edge
  always @(negedge clk_in)
  begin
    cyc <= cyc + 1;
    if (rx_dbl_rst === 1'b1)
      rx_pulses <= rx_pulses + 1;
    if (tx_dbl_rst === 1'b1)
      tx_pulses <= tx_pulses + 1;
    if (cyc == 40000)
    begin
      num_errors = num_errors + 1;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // inputs always change one time unit after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  // stored bits of each register; style reset bits are action bits
  function automatic logic [7:0] mask(input int a);
    case (a)
      57: return 8'h03;
      58, 59, 60: return 8'hFF;
      61: return 8'h0F;
      62: return 8'h3F;
      63: return 8'h7F;
      default: return 8'h00;
    endcase
  endfunction

  // one 16-bit frame; sclk phases of 4 clocks
  task automatic spi(input logic rd, input int a, input logic [7:0] d, output logic [7:0] q);
    logic [15:0] f;
    f = {rd, a[6:0], d};
    q = '0;
    cs_n = 1'b0;
    tick(1);
    for (int k = 15; k >= 0; k--)
    begin
      sdi = f[k];
      tick(4);
      if (rd && k < 8)
      begin
        chk(sdo_oe_out, 1'b1);
        q[k] = sdo_out;
      end
      sclk = 1'b1;
      tick(4);
      sclk = 1'b0;
    end
    tick(6);
    cs_n = 1'b1;
    sdi = $urandom;
    tick(2);
  endtask

  task automatic wr(input int a, input logic [7:0] d);
    logic [7:0] q;
    spi(1'b0, a, d, q);
    if (a >= 57 && a <= 63)
      m[a] = d & mask(a);
  endtask

  task automatic rd(input int a);
    logic [7:0] q;
    spi(1'b1, a, 8'h00, q);
    chk(q, (a >= 57 && a <= 63) ? m[a] : 8'h00);
  endtask

  task automatic check_cfg();
    logic [7:0] r;
    r = m[63];
    chk(tx_style, m[57][0]);
    chk(rx_style, m[57][1]);
    chk(tx_tune, m[58]);
    chk(rx_tune, m[59]);
    chk(tap_dly, m[60]);
    chk(tx_pw, m[62][5:3]);
    chk(rx_pw, m[62][2:0]);
    chk(full_duplex_out, r[0]);
    chk(hd_submode, r[1]);
    chk(hd_bus_pin, r[2]);
    chk(rx_path_enable_out, r[4] ? (r[5] ? 2'b10 : 2'b01) : 2'b11);
    chk(rx_clock_i_side_out, r[4] & r[6]);
    chk(transmit_clock_pin_oe, ~r[0] & ~r[1] & r[3]);
    chk(transmit_clock_pin_pin, r[3] & dll);
  endtask

  // saturating two's complement negation of a 12-bit sample
  function automatic logic [11:0] ng(input logic [11:0] x);
    return (x == 12'h800) ? 12'h7FF : 12'h000 - x;
  endfunction

  task automatic samp(input logic [11:0] ai, input logic [11:0] aq);
    logic [7:0] n;
    logic [11:0] ei, eq, ti, tq;
    n = m[61];
    ti = $urandom;
    tq = $urandom;
    rx_adc = {ai, aq};
    tx_host = {ti, tq};
    dll = $urandom;
    tick(1);
    ei = n[2] ? ng(ai) : ai;
    eq = n[3] ? ng(aq) : aq;
    chk(rx_host_out.i, ei);
    chk(rx_host_out.q, eq);
    chk(rx_single_out, m[63][5] ? ei : eq);
    chk(tx_dac_out.i, n[0] ? ng(ti) : ti);
    chk(tx_dac_out.q, n[1] ? ng(tq) : tq);
  endtask

  initial
  begin
    int a, rp, tp;
    void'($urandom(32'h6400));
    m = '{8'h00, 8'h55, 8'h55, 8'h00, 8'h00, 8'h00, 8'h00};
    tick(8);
    reset_in = 1'b0;
    // reset values of every register and the config outputs
    check_cfg();
    for (a = 57; a <= 64; a++)
      rd(a);
    // doubler reset bits pulse once and do not stick
    rp = rx_pulses;
    tp = tx_pulses;
    wr(57, 8'hC3);
    chk(rx_pulses - rp, 1);
    chk(tx_pulses - tp, 1);
    rd(57);
    check_cfg();
    // every sign inversion code, with the most negative sample included
    for (a = 0; a < 16; a++)
    begin
      wr(61, a[7:0]);
      samp(12'h800, $urandom);
      samp($urandom, 12'h800);
      samp($urandom, $urandom);
    end
    // transmit clock pin in each duplex and submode setting
    for (a = 0; a < 8; a++)
    begin
      wr(63, {4'h0, a[0], 1'b0, a[2:1]});
      check_cfg();
    end
    // random writes including unused bits and one unmapped address
    for (int k = 0; k < 30; k++)
    begin
      a = 57 + $urandom_range(0, 7);
      wr(a, $urandom);
      rd(a);
      check_cfg();
      samp($urandom, $urandom);
      samp($urandom, $urandom);
    end
    // recommended doubler settings, then everything read back
    wr(58, 8'h55);
    wr(59, 8'h55);
    wr(60, 8'h00);
    check_cfg();
    for (a = 57; a <= 63; a++)
      rd(a);
    final_report();
  end
endmodule
